//--- hdl/ric_ctrl.sv
`timescale 1ns/100ps
`include "ric_defines.svh"
// ----------------------------------------------------------------
// Behaviour
// (RULE1) Rate field picks one of thirteen chain taps.
// (RULE2) Rate code to frequency mapping, zero disables.
// (RULE3) One tap feeds square wave and periodic flag.
// (RULE4) Square pin follows tap when enabled, else low.
// (RULE5) Periodic flag set on every falling tap edge.
// (RULE6) Alarm flag when three bytes match or ignore.
// (RULE7) Update-ended flag set every update.
// (RULE8) Interrupt is OR of flag-enable pairs.
// (RULE9) Reading flag register clears all flags.
// (RULE10) Low nibble of flag register reads zero.
// (RULE11) Update runs always; freeze holds host copy.
// (RULE12) Pending bit rises 244 us before transfer.
// (RULE13) Freeze inhibits transfers, clears pending bit.
// (RULE14) Freeze rising clears update interrupt enable.
// (RULE15) Mode bits change only by host writes.
// (RULE16) Divider field: run, hold chain, or stop.
// (RULE17) First update 500 ms after run pattern.
// (RULE18) Format bit selects binary or BCD counting.
// (RULE19) Hour bit selects 24-hour or 12-hour.
// (RULE20) April first Sunday skips two o'clock hour.
// (RULE21) October last Sunday repeats one o'clock once.
// (RULE22) Registers accessible at all times.
// (RULE23) Flag read snapshot; new events held till end.
// (RULE24) Update advances calendar with leap years.
// (RULE25) Fall-back recorded to avoid second repeat.
// ----------------------------------------------------------------
module ric_ctrl import ric_pkg::*; #(
	parameter int OSC_DIV = `RIC_OSC_DIV
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic       i_cs_n,
	input  wire logic       i_ale,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic [7:0] i_ad,
	output logic      [7:0] o_ad,
	output logic            o_ad_oe,
	output logic            o_sqw,
	output logic            o_irq_oe
);

	// ----------------------------------------------------------------
	// Byte format helpers.
	// ----------------------------------------------------------------

	// Host byte to binary value; BCD when the format bit is zero.
	function automatic logic [6:0] dec(input logic [7:0] v, input logic bcd);
		dec = bcd ? ({3'h0, v[7:4]} * `RIC_TEN + {3'h0, v[3:0]}) : v[6:0]; // [RULE18]
	endfunction

	function automatic logic [7:0] enc(input logic [6:0] b, input logic bcd);
		enc = bcd ? {4'(b / `RIC_TEN), 4'(b % `RIC_TEN)} : {1'b0, b};
	endfunction

	// Hours byte to 0..23; in 12-hour form bit 7 marks PM.
	function automatic logic [6:0] hdec(input logic [7:0] v, input logic bcd,
		input logic h24);
		logic [6:0] h;
		h = dec({1'b0, v[6:0]}, bcd);
		if (h24) begin
			hdec = dec(v, bcd);
		end else begin
			hdec = (h == `RIC_NOON ? 7'h00 : h) + (v[7] ? `RIC_NOON : 7'h00); // [RULE19]
		end
	endfunction

	function automatic logic [7:0] henc(input logic [6:0] h, input logic bcd,
		input logic h24);
		logic [6:0] m;
		logic [7:0] e;
		m = h % `RIC_NOON;
		e = enc(m == 7'h00 ? `RIC_NOON : m, bcd);
		henc = h24 ? enc(h, bcd) : {h >= `RIC_NOON, e[6:0]}; // [RULE19]
	endfunction

	// One-second advance of the time bytes, alarm bytes pass unchanged; adj forces the DST hour.
	function automatic logic [9:0][7:0] tick(input logic [9:0][7:0] t,
		input logic bcd, input logic h24, input logic [1:0] adj);
		logic [6:0] s, m, h, w, d, mo, y, dim;
		logic [9:0][7:0] o;
		logic [15:0] m30;
		o = t;
		m30 = `RIC_M30;
		s = dec(t[`RIC_I_SEC], bcd);
		m = dec(t[`RIC_I_MIN], bcd);
		h = hdec(t[`RIC_I_HR], bcd, h24);
		w = dec(t[`RIC_I_DOW], bcd);
		d = dec(t[`RIC_I_DATE], bcd);
		mo = dec(t[`RIC_I_MON], bcd);
		y = dec(t[`RIC_I_YR], bcd);
		// Every fourth year is a leap year across the whole century.
		if (mo == `RIC_FEB) begin
			dim = (y[1:0] == 2'h0) ? `RIC_D29 : `RIC_D28; // [RULE24]
		end else begin
			dim = m30[mo[3:0]] ? `RIC_D30 : `RIC_D31;
		end
		if (s != `RIC_MAX_MS) begin
			s = s + 7'h01;
		end else begin
			s = 7'h00;
			if (m != `RIC_MAX_MS) begin
				m = m + 7'h01;
			end else begin
				m = 7'h00;
				if (h != `RIC_MAX_H) begin
					h = h + 7'h01;
				end else begin
					h = 7'h00;
					w = (w == `RIC_DOW_MAX) ? 7'h01 : w + 7'h01;
					if (d != dim) begin
						d = d + 7'h01;
					end else begin
						d = 7'h01;
						if (mo != `RIC_DEC) begin
							mo = mo + 7'h01;
						end else begin
							mo = 7'h01;
							y = (y == `RIC_MAX_Y) ? 7'h00 : y + 7'h01; // [RULE24]
						end
					end
				end
			end
		end
		if (adj[0]) begin
			h = `RIC_DST_FWD; // [RULE20]
		end
		if (adj[1]) begin
			h = 7'h01; // [RULE21]
		end
		o[`RIC_I_SEC] = enc(s, bcd);
		o[`RIC_I_MIN] = enc(m, bcd);
		o[`RIC_I_HR] = henc(h, bcd, h24);
		o[`RIC_I_DOW] = enc(w, bcd);
		o[`RIC_I_DATE] = enc(d, bcd);
		o[`RIC_I_MON] = enc(mo, bcd);
		o[`RIC_I_YR] = enc(y, bcd);
		tick = o;
	endfunction

	// Alarm byte matches when equal or when its top two bits are set.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		hit = (a[7:6] == 2'b11) || (a == t); // [RULE6]
	endfunction

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	localparam ric_st_s R0 = '{bus: BUS_IDLE, s1: `RIC_RST_SYNC, s2: `RIC_RST_SYNC,
		ra: `RIC_RST_A, rb: `RIC_RST_B, default: '0};

	ric_st_s         r;
	ric_st_s         n;
	logic            run;
	logic            tk;
	logic            upd;
	logic            rdc;
	logic            rd_end;
	logic            wr_go;
	logic            lb;
	logic            hms;
	logic            spring;
	logic            back;
	logic [3:0]      idx;
	logic [2:0]      ev;
	logic [9:0][7:0] adv;

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------

	// The pins are asynchronous to i_mclk, so every control and data pin
	// passes two flops before use. This costs about three cycles of host
	// latency, far below the host cycle time.
	always_comb begin
		n = r;
		n.s1 = {i_cs_n, i_ale, i_rd_n, i_wr_n, i_ad};
		n.s2 = r.s1;
		n.ale_d = r.s2[10];
		n.xfer = 1'b0;
		rd_end = 1'b0;
		wr_go = 1'b0;
		lb = !r.rb[`RIC_B_DM];

		// Stopped oscillator and held chain both leave the chain at zero,
		// so a later run pattern always restarts a full half second.
		run = (r.ra[`RIC_A_DV] == `RIC_DV_RUN); // [RULE16]
		tk = run && (r.pre == 16'(OSC_DIV - 1));
		if (!run) begin
			n.pre = '0;
			n.chn = '0; // [RULE17]
		end else begin
			n.pre = tk ? 16'h0000 : r.pre + 16'h0001;
			n.chn = r.chn + {14'h0000, tk}; // [RULE1]
		end

		// Codes 1 and 2 alias codes 8 and 9; other codes step one tap.
		if (r.ra[`RIC_A_RS] < 4'h3) begin
			idx = r.ra[`RIC_A_RS] + 4'h5; // [RULE2]
		end else begin
			idx = r.ra[`RIC_A_RS] - 4'h2; // [RULE2]
		end
		// A full tap period elapses between falling edges.
		ev[`RIC_F_PF] = (r.ra[`RIC_A_RS] != 4'h0) && r.chn[idx] && !n.chn[idx]; // [RULE3] [RULE5]

		// Update fires once per second on the top stage, set or not.
		upd = !r.chn[14] && n.chn[14]; // [RULE11]
		hms = (hdec(r.itm[`RIC_I_HR], lb, r.rb[`RIC_B_H24]) == 7'h01)
			&& (dec(r.itm[`RIC_I_MIN], lb) == `RIC_MAX_MS)
			&& (dec(r.itm[`RIC_I_SEC], lb) == `RIC_MAX_MS)
			&& (dec(r.itm[`RIC_I_DOW], lb) == 7'h01)
			&& r.rb[`RIC_B_DSE];
		spring = hms && (dec(r.itm[`RIC_I_MON], lb) == `RIC_APR)
			&& (dec(r.itm[`RIC_I_DATE], lb) <= `RIC_WK1_END); // [RULE20]
		back = hms && (dec(r.itm[`RIC_I_MON], lb) == `RIC_OCT)
			&& (dec(r.itm[`RIC_I_DATE], lb) >= `RIC_OCT_LS) && !r.fall; // [RULE21] [RULE25]
		adv = tick(r.itm, lb, r.rb[`RIC_B_H24], {back, spring}); // [RULE24]
		ev[`RIC_F_AF] = upd && hit(r.itm[`RIC_I_ASEC], adv[`RIC_I_SEC])
			&& hit(r.itm[`RIC_I_AMIN], adv[`RIC_I_MIN])
			&& hit(r.itm[`RIC_I_AHR], adv[`RIC_I_HR]); // [RULE6]
		ev[`RIC_F_UF] = upd; // [RULE7]
		if (upd) begin
			n.itm = adv; // [RULE11]
			if (back) begin
				n.fall = 1'b1; // [RULE25]
			end else if (hdec(adv[`RIC_I_HR], lb, r.rb[`RIC_B_H24]) == 7'h00) begin
				n.fall = 1'b0; // [RULE25]
			end
			if (!r.rb[`RIC_B_SET]) begin
				n.usr = adv; // [RULE13]
				n.xfer = 1'b1;
			end
		end

		// Host strobes are served in any cycle, update or not.
		case (r.bus)
			BUS_IDLE: begin
				if (!r.s2[11] && !r.s2[9]) begin
					n.bus = BUS_RD; // [RULE22]
				end else if (!r.s2[11] && !r.s2[8]) begin
					n.bus = BUS_WR; // [RULE22]
				end
			end
			BUS_RD: begin
				if (r.s2[11] || r.s2[9]) begin
					n.bus = BUS_IDLE;
					rd_end = 1'b1;
				end
			end
			BUS_WR: begin
				if (r.s2[8]) begin
					n.bus = BUS_IDLE;
					wr_go = 1'b1;
				end
			end
			default: begin
				n.bus = BUS_IDLE;
			end
		endcase
		if (r.ale_d && !r.s2[10]) begin
			n.addr = r.s2[7:0];
		end

		// Flags stay frozen during a flag read; events meanwhile wait in
		// the pending copy and are posted when the read ends.
		rdc = (r.bus == BUS_RD) && (r.addr == `RIC_OFS_C);
		if (rdc && rd_end) begin
			n.flg = r.pnd | ev; // [RULE9] [RULE23]
			n.pnd = 3'h0;
		end else if (rdc) begin
			n.pnd = r.pnd | ev; // [RULE23]
		end else begin
			n.flg = r.flg | ev; // [RULE5]
		end

		// Host writes; a time write lands in both copies. Flag writes drop.
		if (wr_go) begin
			if (r.addr <= `RIC_OFS_TLAST) begin
				n.usr[r.addr[3:0]] = r.s2[7:0];
				n.itm[r.addr[3:0]] = r.s2[7:0];
			end else if (r.addr == `RIC_OFS_A) begin
				n.ra = r.s2[6:0];
			end else if (r.addr == `RIC_OFS_B) begin
				n.rb = r.s2[7:0]; // [RULE15]
				if (!r.rb[`RIC_B_SET] && r.s2[`RIC_B_SET]) begin
					n.rb[`RIC_B_UIE] = 1'b0; // [RULE14]
				end
			end
		end

		// Pending bit covers the last ticks before the top stage rises.
		n.update_pending = run && !n.rb[`RIC_B_SET] && !n.chn[14]
			&& (n.chn >= `RIC_UIP_START); // [RULE12] [RULE13]
		n.irq = |(n.flg & {n.rb[`RIC_B_PIE], n.rb[`RIC_B_AIE], n.rb[`RIC_B_UIE]}); // [RULE8]
		n.square_out_pin = n.rb[`RIC_B_SQUARE_OUT_ENABLE] && (n.ra[`RIC_A_RS] != 4'h0) && n.chn[idx]; // [RULE4]
		n.doe = (n.bus == BUS_RD);
		n.dout = 8'h00;
		if (r.addr <= `RIC_OFS_TLAST) begin
			n.dout = n.usr[r.addr[3:0]];
		end else if (r.addr == `RIC_OFS_A) begin
			n.dout = {n.update_pending, n.ra};
		end else if (r.addr == `RIC_OFS_B) begin
			n.dout = n.rb;
		end else if (r.addr == `RIC_OFS_C) begin
			n.dout = {n.irq, n.flg, 4'h0}; // [RULE10]
		end
	end

	// State register.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			r <= R0;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from state; the interrupt pin is open drain.
	assign o_ad     = r.dout;
	assign o_ad_oe  = r.doe;
	assign o_sqw    = r.square_out_pin;
	assign o_irq_oe = r.irq;

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_upd_free;
		upd && !rdc;
	endsequence
	sequence s_pf_edge;
		ev[`RIC_F_PF] && !rdc;
	endsequence
	sequence s_rdc_done;
		rdc && rd_end && (ev == 3'h0) && (r.pnd == 3'h0);
	endsequence

	a_sqw_held_low: assert property (!r.rb[`RIC_B_SQUARE_OUT_ENABLE] |-> !o_sqw) // [RULE4]
		else $error("square pin high while disabled");
	a_pf_on_edge: assert property (s_pf_edge |=> r.flg[`RIC_F_PF]) // [RULE5]
		else $error("periodic flag missed a tap edge");
	a_uf_on_update: assert property (s_upd_free |=> r.flg[`RIC_F_UF]) // [RULE7]
		else $error("update flag not set after update");
	a_irq_or_pairs: assert property (o_irq_oe == |(r.flg & r.rb[6:4])) // [RULE8]
		else $error("interrupt line disagrees with flags");
	a_read_clears: assert property (s_rdc_done |=> (r.flg == 3'h0) && !o_irq_oe) // [RULE9]
		else $error("flag read did not clear flags");
	a_rsvd_zero: assert property ((o_ad_oe && r.addr == `RIC_OFS_C) |-> o_ad[3:0] == 4'h0) // [RULE10]
		else $error("reserved flag bits not zero");
	a_freeze_user: assert property ((r.rb[`RIC_B_SET] && !wr_go) |=> $stable(r.usr)) // [RULE11]
		else $error("host copy moved while frozen");
	a_uip_leads: assert property (r.xfer |-> $past(r.update_pending)) // [RULE12]
		else $error("transfer without pending bit");
	a_set_kills_uip: assert property (r.rb[`RIC_B_SET] |-> !r.update_pending) // [RULE13]
		else $error("pending bit high while frozen");
	a_set_clr_uie: assert property ($rose(r.rb[`RIC_B_SET]) |-> !r.rb[`RIC_B_UIE]) // [RULE14]
		else $error("update enable survived freeze");
	a_hold_chain: assert property ((r.ra[`RIC_A_DVH] == `RIC_DV_HOLD) |=> r.chn == 15'h0000) // [RULE16]
		else $error("chain ran in hold pattern");

endmodule // ric_ctrl

//--- hdl/ric_defines.svh
`ifndef RIC_DEFINES_SVH
`define RIC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map: time and alarm bytes first, then control registers.
// ----------------------------------------------------------------
`define RIC_OFS_TLAST 8'h09
`define RIC_OFS_A     8'h0A
`define RIC_OFS_B     8'h0B
`define RIC_OFS_C     8'h0C

// Byte positions inside the time/alarm bank.
`define RIC_I_SEC  0
`define RIC_I_ASEC 1
`define RIC_I_MIN  2
`define RIC_I_AMIN 3
`define RIC_I_HR   4
`define RIC_I_AHR  5
`define RIC_I_DOW  6
`define RIC_I_DATE 7
`define RIC_I_MON  8
`define RIC_I_YR   9

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define RIC_A_DV   6:4
`define RIC_A_DVH  6:5
`define RIC_A_RS   3:0
`define RIC_B_SET  7
`define RIC_B_PIE  6
`define RIC_B_AIE  5
`define RIC_B_UIE  4
`define RIC_B_SQUARE_OUT_ENABLE 3
`define RIC_B_DM   2
`define RIC_B_H24  1
`define RIC_B_DSE  0
`define RIC_F_PF   2
`define RIC_F_AF   1
`define RIC_F_UF   0
`define RIC_DV_RUN  3'b010
`define RIC_DV_HOLD 2'b11

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define RIC_RST_A    7'h00
`define RIC_RST_B    8'h00
`define RIC_RST_SYNC 12'hB00

// ----------------------------------------------------------------
// Timing and calendar constants.
// ----------------------------------------------------------------
`define RIC_MCLK_HZ       250000000
`define RIC_OSC_HZ        32768
`define RIC_OSC_DIV       (`RIC_MCLK_HZ / `RIC_OSC_HZ)
`define RIC_PRE_UPD_US    244
`define RIC_PRE_UPD_TICKS ((`RIC_PRE_UPD_US * `RIC_OSC_HZ + 999999) / 1000000)
`define RIC_UIP_START     (15'h4000 - 15'(`RIC_PRE_UPD_TICKS))
`define RIC_TEN     7'h0A
`define RIC_NOON    7'h0C
`define RIC_MAX_MS  7'h3B
`define RIC_MAX_H   7'h17
`define RIC_MAX_Y   7'h63
`define RIC_DOW_MAX 7'h07
`define RIC_DEC     7'h0C
`define RIC_FEB     7'h02
`define RIC_APR     7'h04
`define RIC_OCT     7'h0A
`define RIC_M30     16'h0A50
`define RIC_D28     7'h1C
`define RIC_D29     7'h1D
`define RIC_D30     7'h1E
`define RIC_D31     7'h1F
`define RIC_WK1_END 7'h07
`define RIC_OCT_LS  7'h19
`define RIC_DST_FWD 7'h03

`endif

//--- hdl/ric_pkg.sv
package ric_pkg;

	// Host strobe tracking states.
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_RD   = 3'b010,
		BUS_WR   = 3'b100
	} ric_bus_e;

	// Complete state of the controller.
	typedef struct packed {
		ric_bus_e        bus;
		logic [11:0]     s1;
		logic [11:0]     s2;
		logic            ale_d;
		logic [7:0]      addr;
		logic [6:0]      ra;
		logic [7:0]      rb;
		logic [2:0]      flg;
		logic [2:0]      pnd;
		logic [15:0]     pre;
		logic [14:0]     chn;
		logic            update_pending;
		logic            xfer;
		logic            fall;
		logic [9:0][7:0] usr;
		logic [9:0][7:0] itm;
		logic [7:0]      dout;
		logic            doe;
		logic            square_out_pin;
		logic            irq;
	} ric_st_s;

endpackage

//--- test/ric_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host processor model on the multiplexed address/data bus.
// ----------------------------------------------------------------
module ric_host (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_ad,
	input  wire logic       i_ad_oe,
	output logic            o_cs_n,
	output logic            o_ale,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic      [7:0] o_ad
);
	// Idle pins; the bus value is inverted on release so stale data never reads back.
	initial begin
		o_cs_n = 1'b1;
		o_ale  = 1'b0;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_ad   = 8'h00;
	end

	// Address phase: the address is held well past the fall of the latch strobe.
	task automatic addr_ph(input logic [7:0] a);
		@(negedge i_mclk);
		o_ad  = a;
		o_ale = 1'b1;
		repeat (3) @(negedge i_mclk);
		o_ale = 1'b0;
		repeat (4) @(negedge i_mclk);
	endtask

	// Write cycle; data stays put after the strobe rises because it is taken late.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_ph(a);
		o_ad   = d;
		o_cs_n = 1'b0;
		@(negedge i_mclk);
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_mclk);
		o_wr_n = 1'b1;
		repeat (5) @(negedge i_mclk);
		o_cs_n = 1'b1;
		o_ad   = ~d;
		repeat (3) @(negedge i_mclk);
	endtask

	// Read cycle with bounded waits on the device's output enable.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int n;
		addr_ph(a);
		o_ad   = ~a;
		o_cs_n = 1'b0;
		@(negedge i_mclk);
		o_rd_n = 1'b0;
		ok     = 1'b0;
		for (n = 0; n < 10 && !ok; n++) begin
			@(negedge i_mclk);
			ok = (i_ad_oe === 1'b1);
		end
		@(negedge i_mclk);
		d      = i_ad;
		o_rd_n = 1'b1;
		o_cs_n = 1'b1;
		for (n = 0; n < 10 && i_ad_oe !== 1'b0; n++) begin
			@(negedge i_mclk);
		end
		if (i_ad_oe !== 1'b0) begin
			ok = 1'b0;
		end
		@(negedge i_mclk);
	endtask
endmodule // ric_host

//--- test/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench for the clock control block.
// ----------------------------------------------------------------
module testbench;
	logic       i_mclk;
	logic       i_rstn;
	logic       cs_n;
	logic       ale;
	logic       rd_n;
	logic       wr_n;
	logic [7:0] ad_h;
	logic [7:0] o_ad;
	logic       o_ad_oe;
	logic       o_sqw;
	logic       o_irq_oe;
	logic [7:0] ad_bus;
	int         num_errors;
	int         n_compared;

	// Bus wire: the device wins while it drives, otherwise the host value.
	assign ad_bus = o_ad_oe ? o_ad : ad_h;

	ric_ctrl #(.OSC_DIV(2)) ric_ctrl_inst (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_cs_n  (cs_n),
		.i_ale   (ale),
		.i_rd_n  (rd_n),
		.i_wr_n  (wr_n),
		.i_ad    (ad_bus),
		.o_ad    (o_ad),
		.o_ad_oe (o_ad_oe),
		.o_sqw   (o_sqw),
		.o_irq_oe(o_irq_oe)
	);

	ric_host ric_host_inst (
		.i_mclk (i_mclk),
		.i_ad   (ad_bus),
		.i_ad_oe(o_ad_oe),
		.o_cs_n (cs_n),
		.o_ale  (ale),
		.o_rd_n (rd_n),
		.o_wr_n (wr_n),
		.o_ad   (ad_h)
	);

	// 250 MHz clock.
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Range compare; an unknown makes ok unknown and so counts as a mismatch.
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got,
			input int tol);
		logic ok;
		ok = (got + tol >= ex) && (got <= ex + tol);
		n_compared++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ric_host_inst.wr(a, d);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
		logic [7:0] d;
		logic       ok;
		ric_host_inst.rd(a, d, ok);
		if (!ok) begin
			$display("MISMATCH %s expected handshake seen none", nm);
			num_errors++;
			summarize();
		end
		chk(nm, {8'h00, ex}, {8'h00, d}, 0);
	endtask

	// Counts rising edges of the square output over n cycles.
	task automatic count_rise(input int n, output logic [15:0] c);
		logic prev;
		c    = 16'h0000;
		prev = o_sqw;
		repeat (n) begin
			@(negedge i_mclk);
			if (o_sqw && !prev) begin
				c++;
			end
			prev = o_sqw;
		end
	endtask

	logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
	logic [15:0] cnt;
	int          h;
	int          t;

	// Main sequence; inputs change at the falling edge only.
	initial begin
		num_errors = 0;
		n_compared = 0;
		i_rstn     = 1'b0;
		repeat (12) @(negedge i_mclk);
		i_rstn = 1'b1;

		rd_chk("A reset", 8'h0A, 8'h00);
		rd_chk("B reset", 8'h0B, 8'h00);
		rd_chk("C reset", 8'h0C, 8'h00);
		rd_chk("unmapped", 8'h20, 8'h00);
		wr(8'h0B, 8'h67);
		rd_chk("B rw", 8'h0B, 8'h67);
		wr(8'h0A, 8'h8B);
		rd_chk("A ro bit", 8'h0A, 8'h0B);
		wr(8'h0B, 8'h10);
		wr(8'h0B, 8'h90);
		rd_chk("B freeze", 8'h0B, 8'h80);
		$display("test registers done");

		// Every rate class, with 8 cycles per period at the fastest tap.
		wr(8'h0B, 8'h08);
		foreach (codes[i]) begin
			wr(8'h0A, {4'h2, codes[i]});
			h = (codes[i] <= 4'h2) ? int'(codes[i]) + 4 : int'(codes[i]) - 3;
			repeat (64) @(negedge i_mclk);
			count_rise(1024, cnt);
			chk("sqw edges", (codes[i] == 4'h0) ? 16'h0 : 16'(128 >> h), cnt, 1);
		end
		wr(8'h0A, 8'h23);
		wr(8'h0B, 8'h00);
		count_rise(256, cnt);
		chk("sqw off", 16'h0000, cnt, 0);
		chk("sqw low", 16'h0000, {15'h0, o_sqw}, 0);
		$display("test rates done");

		// Periodic flag without and with its enable, then clear by read.
		rd_chk("C clr", 8'h0C, 8'h40);
		repeat (32) @(negedge i_mclk);
		chk("irq masked", 16'h0000, {15'h0, o_irq_oe}, 0);
		wr(8'h0B, 8'h40);
		repeat (20) @(negedge i_mclk);
		chk("irq pf", 16'h0001, {15'h0, o_irq_oe}, 0);
		wr(8'h0A, 8'h20);
		repeat (20) @(negedge i_mclk);
		rd_chk("C pf", 8'h0C, 8'hC0);
		chk("irq clr", 16'h0000, {15'h0, o_irq_oe}, 0);
		wr(8'h0C, 8'hFF);
		rd_chk("C empty", 8'h0C, 8'h00);
		$display("test periodic done");

		// First update after the run pattern, with all alarm bytes ignored.
		wr(8'h01, 8'hC0);
		wr(8'h03, 8'hC0);
		wr(8'h05, 8'hFF);
		wr(8'h00, 8'h00);
		wr(8'h0B, 8'h12);
		wr(8'h0A, 8'h00);
		wr(8'h0A, 8'h20);
		for (t = 0; t < 40000 && o_irq_oe !== 1'b1; t++) begin
			@(negedge i_mclk);
		end
		chk("update time", 16'h8000, 16'(t), 64);
		if (o_irq_oe !== 1'b1) begin
			summarize();
		end
		rd_chk("C update", 8'h0C, 8'hB0);
		rd_chk("seconds", 8'h00, 8'h01);
		$display("test update done");
		summarize();
	end
endmodule // testbench
